// File: src/sitmr_pkg.sv
// package of register map, field positions and reset values for the slow interval timer
package sitmr_pkg;
    // ==========================================================
    // register offsets (word indices, compared with wb_adr_i above bit 1; printed offsets are not all word aligned)
    localparam logic [15:0] SITMR_IDX_CLK_CTL = 16'h5065;
    localparam logic [15:0] SITMR_IDX_CTL     = 16'h50c0;
    localparam logic [15:0] SITMR_IDX_CNT     = 16'h50c1;
    localparam logic [15:0] SITMR_IDX_CMP     = 16'h50c2;
    localparam logic [15:0] SITMR_IDX_IMSK    = 16'h50c3;
    localparam logic [15:0] SITMR_IDX_IFLG    = 16'h50c4;
    localparam int          SITMR_ADDR_W      = 18;
    // ==========================================================
    // field positions
    localparam int SITMR_BIT_RUN   = 0;
    localparam int SITMR_BIT_MODE  = 1;
    localparam int SITMR_BIT_SRST  = 4;
    localparam int SITMR_BIT_CE    = 0;
    localparam int SITMR_DIV_LSB   = 1;
    localparam int SITMR_DIV_MSB   = 3;
    localparam int SITMR_BIT_IE    = 0;
    localparam int SITMR_BIT_IF    = 0;
    // ==========================================================
    // reset values
    localparam logic [7:0] SITMR_RST_CNT = 8'h00;
    localparam logic [7:0] SITMR_RST_CMP = 8'h00;
    localparam logic [2:0] SITMR_RST_DIV = 3'h0;
    localparam logic [2:0] SITMR_DIV_MAX = 3'h5;
    localparam logic [4:0] SITMR_RST_PRE = 5'h00;
endpackage

// File: src/sitmr_slow_interval_timer.sv
// slow interval timer: 8-bit up counter with compare match, divider, and wishbone slave
// Behaviour
// RULE1 - 8-bit up counter and separate 8-bit compare register.
// RULE2 - software may read the live counter value at any time.
// RULE3 - counter equal to compare value raises a match event.
// RULE4 - repeat mode: match clears counter, counting continues, event signalled.
// RULE5 - one-shot mode: match clears counter then stops the run bit.
// RULE6 - software changes count mode only while stopped.
// RULE7 - divider field selects /1 to /32 for codes 0 to 5; 6,7 reserved.
// RULE8 - clock supply enable resets to 0 and gates the count clock.
// RULE9 - software changes divider selection only while stopped.
// RULE10 - writing 1 to soft reset bit clears the counter.
// RULE11 - software resets the counter before starting; hardware clears on match.
// RULE12 - run bit starts counting; clearing it holds the count for resume.
// RULE13 - run and soft reset together clear the counter then count.
// RULE14 - match sets flag only when enabled; flag drives interrupt request.
// RULE15 - writing 1 clears the flag, 0 has no effect.
// RULE16 - counter increments once per enabled tick; period is compare plus one.
// RULE17 - all counter, compare, control and flag state is zero after reset.
`timescale 1ns/1ns
`default_nettype none
module sitmr_slow_interval_timer
    import sitmr_pkg::*;
#(
    parameter int DATA_W = 32
) (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    resetn,
    // low speed oscillator from another domain
    input  wire logic                    lowSpeedOscillator,
    // wishbone classic slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [SITMR_ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [DATA_W-1:0]       wb_dat_i,
    output logic      [DATA_W-1:0]       wb_dat_o,
    output logic                         wb_ack_o,
    output logic                         wb_err_o,
    // request to the interrupt controller
    output logic                         matchIrq
);
    // ==========================================================
    // state
    typedef struct packed {
        logic [1:0]        oscSync;
        logic              oscPrev;
        logic [4:0]        preDiv;
        logic [7:0]        count;                 // [RULE1]
        logic [7:0]        compare;
        logic              runStopControl;
        logic              countModeSelect;
        logic [2:0]        clockDividerSelect;
        logic              clockSupplyEnable;
        logic              matchInterruptEnable;
        logic              matchInterruptFlag;
        logic              ack;
        logic              err;
        logic [DATA_W-1:0] rdata;
        logic              irq;
    } sitmr_state_s;

    sitmr_state_s state_reg;
    sitmr_state_s state_next;

    logic [15:0] byteAddr;
    logic        wbReq;
    logic        wrEn;
    logic        oscRise;
    logic        tick;
    logic        match;
    logic        srstWr;

    // register index decode, used by both read and write paths
    function automatic logic hit(input logic [15:0] a, input logic [15:0] idx);
        hit = (a == idx);
    endfunction

    // ==========================================================
    // combinational decode
    assign byteAddr = wb_adr_i[SITMR_ADDR_W-1:2];
    assign wbReq    = wb_cyc_i && wb_stb_i && !state_reg.ack && !state_reg.err;
    assign wrEn     = wbReq && wb_we_i && wb_sel_i[0];
    // oscillator edge taken only from the second sync stage
    assign oscRise  = state_reg.oscSync[1] && !state_reg.oscPrev;
    // divided tick: divider code n of 0 to 5 passes one of every 2^n rising edges [RULE7]
    assign tick     = oscRise && state_reg.clockSupplyEnable &&                        // [RULE8]
                      (state_reg.clockDividerSelect <= SITMR_DIV_MAX) &&
                      ((state_reg.preDiv & ((5'h01 << state_reg.clockDividerSelect) - 5'h01)) == 5'h00);
    // a match is only recognised on a count tick while running [RULE3]
    assign match    = tick && state_reg.runStopControl && (state_reg.count == state_reg.compare);
    assign srstWr   = wrEn && hit(byteAddr, SITMR_IDX_CTL) && wb_dat_i[SITMR_BIT_SRST];

    // ==========================================================
    // next state
    always_comb begin
        state_next            = state_reg;
        state_next.oscSync    = {state_reg.oscSync[0], lowSpeedOscillator};
        state_next.oscPrev    = state_reg.oscSync[1];
        state_next.ack        = 1'b0;
        state_next.err        = 1'b0;
        if (oscRise) begin
            state_next.preDiv = state_reg.preDiv + 5'h01;
        end

        // counting; reserved divider codes give no tick at all
        if (match) begin
            state_next.count = SITMR_RST_CNT;                                          // [RULE4]
            if (state_reg.countModeSelect) begin
                state_next.runStopControl = 1'b0;                                      // [RULE5]
            end
        end else if (tick && state_reg.runStopControl) begin
            state_next.count = state_reg.count + 8'h01;                                // [RULE16]
        end

        // software writes; byte lane 0 carries each 8-bit register
        if (wrEn) begin
            if (hit(byteAddr, SITMR_IDX_CTL)) begin
                state_next.runStopControl  = wb_dat_i[SITMR_BIT_RUN];                  // [RULE12]
                state_next.countModeSelect = wb_dat_i[SITMR_BIT_MODE];
            end
            if (hit(byteAddr, SITMR_IDX_CLK_CTL)) begin
                state_next.clockSupplyEnable  = wb_dat_i[SITMR_BIT_CE];
                state_next.clockDividerSelect = wb_dat_i[SITMR_DIV_MSB:SITMR_DIV_LSB];
            end
            if (hit(byteAddr, SITMR_IDX_CMP)) begin
                state_next.compare = wb_dat_i[7:0];
            end
            if (hit(byteAddr, SITMR_IDX_IMSK)) begin
                state_next.matchInterruptEnable = wb_dat_i[SITMR_BIT_IE];
            end
            if (hit(byteAddr, SITMR_IDX_IFLG) && wb_dat_i[SITMR_BIT_IF]) begin
                state_next.matchInterruptFlag = 1'b0;                                  // [RULE15]
            end
        end
        // soft reset wins over a tick; with run set, counting restarts from zero
        if (srstWr) begin
            state_next.count = SITMR_RST_CNT;                                          // [RULE10] [RULE13]
        end
        // set wins over a same-cycle clear
        if (match && state_reg.matchInterruptEnable) begin
            state_next.matchInterruptFlag = 1'b1;                                      // [RULE14]
        end
        state_next.irq = state_next.matchInterruptFlag;

        // bus answer one cycle after the request
        if (wbReq) begin
            state_next.rdata = '0;
            if (hit(byteAddr, SITMR_IDX_CTL)) begin
                state_next.rdata[SITMR_BIT_RUN]  = state_reg.runStopControl;
                state_next.rdata[SITMR_BIT_MODE] = state_reg.countModeSelect;
                state_next.ack = 1'b1;
            end else if (hit(byteAddr, SITMR_IDX_CLK_CTL)) begin
                state_next.rdata[SITMR_BIT_CE] = state_reg.clockSupplyEnable;
                state_next.rdata[SITMR_DIV_MSB:SITMR_DIV_LSB] = state_reg.clockDividerSelect;
                state_next.ack = 1'b1;
            end else if (hit(byteAddr, SITMR_IDX_CNT)) begin
                state_next.rdata[7:0] = state_reg.count;                               // [RULE2]
                state_next.ack = 1'b1;
            end else if (hit(byteAddr, SITMR_IDX_CMP)) begin
                state_next.rdata[7:0] = state_reg.compare;
                state_next.ack = 1'b1;
            end else if (hit(byteAddr, SITMR_IDX_IMSK)) begin
                state_next.rdata[SITMR_BIT_IE] = state_reg.matchInterruptEnable;
                state_next.ack = 1'b1;
            end else if (hit(byteAddr, SITMR_IDX_IFLG)) begin
                state_next.rdata[SITMR_BIT_IF] = state_reg.matchInterruptFlag;
                state_next.ack = 1'b1;
            end else begin
                state_next.err = 1'b1;                                                 // unmapped address
            end
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= '0;                                                           // [RULE17]
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // outputs straight from flip-flops
    assign wb_dat_o = state_reg.rdata;
    assign wb_ack_o = state_reg.ack;
    assign wb_err_o = state_reg.err;
    assign matchIrq = state_reg.irq;

    // ==========================================================
    // assertions
    sequence s_matchRepeat;
        match && !state_reg.countModeSelect && !srstWr;
    endsequence

    // a bus write in the match cycle may move the run bit, so it is left out here
    sequence s_busQuiet;
        !wrEn;
    endsequence

    property p_repeatClears;
        @(posedge clk) disable iff (!resetn)
        s_matchRepeat and s_busQuiet |=> state_reg.count == 8'h00 && state_reg.runStopControl;
    endproperty
    a_repeatClears: assert property (p_repeatClears) else $error("repeat match did not clear"); // [RULE4]

    property p_oneShotStops;
        @(posedge clk) disable iff (!resetn)
        match && state_reg.countModeSelect && !wrEn |=> state_reg.count == 8'h00 && !state_reg.runStopControl;
    endproperty
    a_oneShotStops: assert property (p_oneShotStops) else $error("one-shot did not stop"); // [RULE5]

    property p_increment;
        @(posedge clk) disable iff (!resetn)
        tick && state_reg.runStopControl && !match && !srstWr |=> state_reg.count == $past(state_reg.count) + 8'h01;
    endproperty
    a_increment: assert property (p_increment) else $error("counter did not increment"); // [RULE16]

    property p_holdWhenStopped;
        @(posedge clk) disable iff (!resetn)
        !state_reg.runStopControl && !srstWr |=> $stable(state_reg.count);
    endproperty
    a_holdWhenStopped: assert property (p_holdWhenStopped) else $error("count moved while stopped"); // [RULE12]

    property p_softReset;
        @(posedge clk) disable iff (!resetn)
        srstWr |=> state_reg.count == 8'h00;
    endproperty
    a_softReset: assert property (p_softReset) else $error("soft reset ignored"); // [RULE10]

    property p_noTickGated;
        @(posedge clk) disable iff (!resetn)
        !state_reg.clockSupplyEnable && !srstWr |=> $stable(state_reg.count);
    endproperty
    a_noTickGated: assert property (p_noTickGated) else $error("count moved with clock gated"); // [RULE8]

    property p_flagSet;
        @(posedge clk) disable iff (!resetn)
        match && state_reg.matchInterruptEnable |=> state_reg.matchInterruptFlag && matchIrq;
    endproperty
    a_flagSet: assert property (p_flagSet) else $error("flag or request missing"); // [RULE14]

    property p_flagNoSetDisabled;
        @(posedge clk) disable iff (!resetn)
        !state_reg.matchInterruptFlag && !(match && state_reg.matchInterruptEnable) |=> !state_reg.matchInterruptFlag;
    endproperty
    a_flagNoSetDisabled: assert property (p_flagNoSetDisabled) else $error("flag set without cause"); // [RULE14]

    property p_flagClear;
        @(posedge clk) disable iff (!resetn)
        wrEn && hit(byteAddr, SITMR_IDX_IFLG) && wb_dat_i[0] && !match |=> !state_reg.matchInterruptFlag;
    endproperty
    a_flagClear: assert property (p_flagClear) else $error("flag clear failed"); // [RULE15]

    property p_ackOneCycle;
        @(posedge clk) disable iff (!resetn)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ackOneCycle: assert property (p_ackOneCycle) else $error("ack held too long"); // [RULE2]

    // ==========================================================
    // reset state, register writes and the bus answer
    sequence s_ctlWrite;
        wrEn && hit(byteAddr, SITMR_IDX_CTL);
    endsequence

    sequence s_noFlagClear;
        !(wrEn && hit(byteAddr, SITMR_IDX_IFLG) && wb_dat_i[SITMR_BIT_IF]);
    endsequence

    // no disable here: the cleared state itself is what is looked at
    property p_resetState;
        @(posedge clk)
        !resetn |=> state_reg.count == 8'h00 && state_reg.compare == 8'h00 && !state_reg.runStopControl &&
                    !state_reg.countModeSelect && !state_reg.clockSupplyEnable && !matchIrq &&
                    state_reg.clockDividerSelect == 3'h0 && !state_reg.matchInterruptEnable &&
                    !state_reg.matchInterruptFlag;
    endproperty
    a_resetState: assert property (p_resetState) else $error("state not cleared by reset"); // [RULE17]

    property p_runWrite;
        @(posedge clk) disable iff (!resetn)
        s_ctlWrite |=> state_reg.runStopControl == $past(wb_dat_i[SITMR_BIT_RUN]);
    endproperty
    a_runWrite: assert property (p_runWrite) else $error("run bit not taken from write"); // [RULE12]

    property p_startFresh;
        @(posedge clk) disable iff (!resetn)
        srstWr && wb_dat_i[SITMR_BIT_RUN] |=> state_reg.count == 8'h00 && state_reg.runStopControl;
    endproperty
    a_startFresh: assert property (p_startFresh) else $error("run with reset did not restart"); // [RULE13]

    property p_flagHolds;
        @(posedge clk) disable iff (!resetn)
        state_reg.matchInterruptFlag and s_noFlagClear |=> state_reg.matchInterruptFlag;
    endproperty
    a_flagHolds: assert property (p_flagHolds) else $error("flag lost without clear"); // [RULE15]

    property p_compareWrite;
        @(posedge clk) disable iff (!resetn)
        wrEn && hit(byteAddr, SITMR_IDX_CMP) |=> state_reg.compare == $past(wb_dat_i[7:0]);
    endproperty
    a_compareWrite: assert property (p_compareWrite) else $error("compare not written"); // [RULE1]

    property p_compareKeep;
        @(posedge clk) disable iff (!resetn)
        !(wrEn && hit(byteAddr, SITMR_IDX_CMP)) |=> $stable(state_reg.compare);
    endproperty
    a_compareKeep: assert property (p_compareKeep) else $error("compare moved without write"); // [RULE1]

    property p_countRead;
        @(posedge clk) disable iff (!resetn)
        wbReq && !wb_we_i && hit(byteAddr, SITMR_IDX_CNT) |=> wb_ack_o && wb_dat_o[7:0] == $past(state_reg.count);
    endproperty
    a_countRead: assert property (p_countRead) else $error("count read wrong"); // [RULE2]

    property p_answerNext;
        @(posedge clk) disable iff (!resetn)
        wbReq |=> wb_ack_o || wb_err_o;
    endproperty
    a_answerNext: assert property (p_answerNext) else $error("no answer after request");

    property p_quietBus;
        @(posedge clk) disable iff (!resetn)
        !wbReq |=> !wb_ack_o && !wb_err_o;
    endproperty
    a_quietBus: assert property (p_quietBus) else $error("answer without request");

    property p_upperZero;
        @(posedge clk) disable iff (!resetn)
        wb_ack_o |-> wb_dat_o[DATA_W-1:8] == '0;
    endproperty
    a_upperZero: assert property (p_upperZero) else $error("upper read bits not zero");

    property p_reservedNoCount;
        @(posedge clk) disable iff (!resetn)
        state_reg.clockDividerSelect > SITMR_DIV_MAX && !srstWr |=> $stable(state_reg.count);
    endproperty
    a_reservedNoCount: assert property (p_reservedNoCount) else $error("count moved on reserved divider"); // [RULE7]

    property p_errOneCycle;
        @(posedge clk) disable iff (!resetn)
        wb_err_o |=> !wb_err_o;
    endproperty
    a_errOneCycle: assert property (p_errOneCycle) else $error("err held too long");
endmodule
`default_nettype wire

// File: sim/sitmr_slow_interval_timer_tb.sv
// self-checking testbench for the slow interval timer through its wishbone registers
`timescale 1ns/1ns
`default_nettype none
module sitmr_slow_interval_timer_tb;
    import sitmr_pkg::*;
    // ==========================================================
    // stimulus and observation signals
    logic                    clk = 1'b0;
    logic                    resetn = 1'b0;
    logic                    lowSpeedOscillator = 1'b0;
    logic                    wb_cyc_i = 1'b0;
    logic                    wb_stb_i = 1'b0;
    logic                    wb_we_i = 1'b0;
    logic [SITMR_ADDR_W-1:0] wb_adr_i = '0;
    logic [3:0]              wb_sel_i = 4'hf;
    logic [31:0]             wb_dat_i = '0;
    logic [31:0]             wb_dat_o;
    logic                    wb_ack_o;
    logic                    wb_err_o;
    logic                    matchIrq;
    int                      fails = 0;
    int                      comparisons = 0;
    logic [31:0]             rv;
    logic                    ev;
    // ==========================================================
    // clock and design
    always #4 clk = ~clk;
    sitmr_slow_interval_timer sitmr_slow_interval_timer_i (
        .clk(clk), .resetn(resetn), .lowSpeedOscillator(lowSpeedOscillator),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .matchIrq(matchIrq));
    // ==========================================================
    // shared helpers
    task automatic close_out();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one classic cycle; waits a bounded time for ack or err, then idles one cycle
    task automatic xfer(input logic we, input logic [15:0] idx, input logic [7:0] wd,
                        output logic [31:0] rd, output logic er);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h000000, wd};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            fails++;
            close_out();
        end
        rd = wb_dat_o;
        er = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
        xfer(1'b1, idx, wd, rv, ev);
    endtask
    task automatic rd(input logic [15:0] idx);
        xfer(1'b0, idx, 8'h00, rv, ev);
    endtask
    // oscillator pulses slow enough for the two-flop synchroniser to see every edge
    task automatic osc(input int n);
        repeat (n) begin
            lowSpeedOscillator <= 1'b1;
            repeat (6) @(posedge clk);
            lowSpeedOscillator <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        check("irq", {31'h0, matchIrq}, 32'h0);
        for (int i = 0; i < 6; i++) begin
            rd(i == 0 ? SITMR_IDX_CLK_CTL : SITMR_IDX_CTL + 16'(i - 1));
            check("reset value", rv, 32'h0);
        end
        xfer(1'b0, 16'h50c5, 8'h00, rv, ev);
        check("unmapped err", {31'h0, ev}, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_repeat();
        wr(SITMR_IDX_CLK_CTL, 8'h01);
        wr(SITMR_IDX_CMP, 8'h02);
        wr(SITMR_IDX_IMSK, 8'h01);
        wr(SITMR_IDX_CNT, 8'h55);
        wr(SITMR_IDX_CTL, 8'h11); // soft reset and start in one write
        for (int k = 1; k <= 5; k++) begin
            osc(1);
            rd(SITMR_IDX_CNT);
            check("count", rv, 32'(k % 3));
        end
        check("irq set", {31'h0, matchIrq}, 32'h1);
        wr(SITMR_IDX_IFLG, 8'h00);
        rd(SITMR_IDX_IFLG);
        check("flag kept", rv, 32'h1);
        wr(SITMR_IDX_CTL, 8'h00);
        wr(SITMR_IDX_IFLG, 8'h01);
        rd(SITMR_IDX_IFLG);
        check("flag cleared", rv, 32'h0);
        check("irq cleared", {31'h0, matchIrq}, 32'h0);
        $display("test repeat done");
    endtask
    task automatic t_hold();
        wr(SITMR_IDX_CMP, 8'hff);
        wr(SITMR_IDX_IMSK, 8'h00);
        wr(SITMR_IDX_CTL, 8'h11);
        osc(3);
        wr(SITMR_IDX_CTL, 8'h00);
        osc(2);
        rd(SITMR_IDX_CNT);
        check("held count", rv, 32'h3);
        wr(SITMR_IDX_CTL, 8'h01);
        osc(1);
        rd(SITMR_IDX_CNT);
        check("resumed count", rv, 32'h4);
        wr(SITMR_IDX_CTL, 8'h10);
        rd(SITMR_IDX_CNT);
        check("soft reset", rv, 32'h0);
        $display("test hold done");
    endtask
    task automatic t_oneshot();
        wr(SITMR_IDX_CMP, 8'h01);
        wr(SITMR_IDX_IMSK, 8'h01);
        wr(SITMR_IDX_CTL, 8'h12); // mode changed while stopped
        wr(SITMR_IDX_CTL, 8'h13);
        osc(4);
        rd(SITMR_IDX_CNT);
        check("one-shot count", rv, 32'h0);
        rd(SITMR_IDX_CTL);
        check("one-shot stopped", rv, 32'h2);
        check("one-shot irq", {31'h0, matchIrq}, 32'h1);
        wr(SITMR_IDX_IFLG, 8'h01);
        wr(SITMR_IDX_IMSK, 8'h00);
        wr(SITMR_IDX_CTL, 8'h10);
        $display("test one-shot done");
    endtask
    task automatic t_divider();
        wr(SITMR_IDX_CMP, 8'hff);
        for (int c = 0; c < 9; c++) begin
            wr(SITMR_IDX_CTL, 8'h10);
            // selection changed only while stopped; c 8 leaves the supply gated
            wr(SITMR_IDX_CLK_CTL, c == 8 ? 8'h00 : {4'h0, 3'(c), 1'b1});
            wr(SITMR_IDX_CTL, 8'h01);
            osc(2 << (c > 5 ? 0 : c));
            wr(SITMR_IDX_CTL, 8'h00);
            rd(SITMR_IDX_CNT);
            check("divided count", rv, c < 6 ? 32'h2 : 32'h0);
        end
        // compare zero matches on every tick while the enable stays off
        wr(SITMR_IDX_CLK_CTL, 8'h01);
        wr(SITMR_IDX_CMP, 8'h00);
        wr(SITMR_IDX_CTL, 8'h01);
        osc(2);
        wr(SITMR_IDX_CTL, 8'h00);
        rd(SITMR_IDX_CNT);
        check("compare zero count", rv, 32'h0);
        rd(SITMR_IDX_IFLG);
        check("flag masked", rv, 32'h0);
        $display("test divider done");
    endtask
    // ==========================================================
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_repeat();
        t_hold();
        t_oneshot();
        t_divider();
        close_out();
    end
endmodule
`default_nettype wire
